// ===== hdl/plc_defs.svh
`ifndef PLC_DEFS_SVH
`define PLC_DEFS_SVH
`define PLC_ADDR_W 10
`define PLC_OFF_DET 10'h026
`define PLC_OFF_FLT 10'h027
`define PLC_OFF_BAND 10'h028
`define PLC_OFF_SCR_B 10'h0fe
`define PLC_OFF_SCR_C 10'h0ff
`define PLC_OFF_UPDATE 10'h00f
`define PLC_RST_DET 8'h01
`define PLC_RST_FLT 8'h13
`define PLC_RST_BAND 8'h00
`define PLC_RST_SCR 8'h00
`define PLC_DET_MASK 8'h03
`define PLC_FLT_MASK 8'h3f
`define PLC_BAND_MASK 8'h1f
`define PLC_UPDATE_BIT 0
`endif

// ===== hdl/plc_pkg.sv
package plc_pkg;
  typedef struct packed {
    logic wide_pulse_select;
    logic comparator_on;
  } plc_det_t;
  typedef struct packed {
    logic [3:0] filter_cap_code;
    logic filter_bias_on;
    logic filter_amp_on;
  } plc_flt_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [9:0] addr;
    logic [7:0] wdata;
  } plc_bus_t;
endpackage

// ===== hdl/plc_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for a bus of levels
module plc_sync #(
  parameter int W = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// ===== hdl/plc_regs.sv
`timescale 1ns/1ps
`include "plc_defs.svh"
module plc_regs (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic [9:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [4:0] CAL_BAND,
  output logic [7:0] RDATA,
  output plc_pkg::plc_det_t DET_OUT,
  output plc_pkg::plc_flt_t FLT_OUT
);
  logic [7:0] det_reg;
  logic [7:0] flt_reg;
  logic [7:0] scr_b_reg;
  logic [7:0] scr_c_reg;
  logic [4:0] band_sync;
  logic update;
  logic [7:0] rd_next;
  localparam logic [7:0] rst_det_val = `PLC_RST_DET;
  localparam logic [7:0] rst_flt_val = `PLC_RST_FLT;

  ////////////////////////////////////////////////////////////////////////
  plc_sync #(.W(5)) u_band_sync (
    .clk(CLK_SYS),
    .rst_n(RESET_N),
    .d(CAL_BAND),
    .q(band_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  // Buffered register writes
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      det_reg <= `PLC_RST_DET;
      flt_reg <= `PLC_RST_FLT;
    end else if (WR) begin
      if (ADDR == `PLC_OFF_DET) begin
        det_reg <= WDATA & `PLC_DET_MASK;
      end
      if (ADDR == `PLC_OFF_FLT) begin
        flt_reg <= WDATA & `PLC_FLT_MASK;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      scr_b_reg <= `PLC_RST_SCR;
      scr_c_reg <= `PLC_RST_SCR;
    end else if (WR) begin
      if (ADDR == `PLC_OFF_SCR_B) begin
        scr_b_reg <= WDATA;
      end
      if (ADDR == `PLC_OFF_SCR_C) begin
        scr_c_reg <= WDATA;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Update strobe is live, self clearing
  assign update = WR && (ADDR == `PLC_OFF_UPDATE) && WDATA[`PLC_UPDATE_BIT];

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      DET_OUT <= plc_pkg::plc_det_t'(rst_det_val[1:0]);
      FLT_OUT <= plc_pkg::plc_flt_t'(rst_flt_val[5:0]);
    end else if (update) begin
      DET_OUT <= plc_pkg::plc_det_t'(det_reg[1:0]);
      FLT_OUT <= plc_pkg::plc_flt_t'(flt_reg[5:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux; band has no write path
  always_comb begin
    rd_next = 8'h00;
    unique case (ADDR)
      `PLC_OFF_DET: rd_next = det_reg;
      `PLC_OFF_FLT: rd_next = flt_reg;
      `PLC_OFF_BAND: rd_next = {3'h0, band_sync};
      `PLC_OFF_SCR_B: rd_next = scr_b_reg;
      `PLC_OFF_SCR_C: rd_next = scr_c_reg;
      default: rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      RDATA <= rd_next;
    end else begin
      RDATA <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  property p_det_reset_val;
    @(posedge CLK_SYS) $rose(RESET_N) |-> det_reg == 8'h01;
  endproperty
  a_det_reset_val: assert property (p_det_reset_val) else $error("detector reset");

  property p_wide_write;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      WR && ADDR == 10'h026 |=> det_reg[1] == $past(WDATA[1]);
  endproperty
  a_wide_write: assert property (p_wide_write) else $error("wide pulse write");

  property p_det_upper_zero;
    @(posedge CLK_SYS) disable iff (!RESET_N) det_reg[7:2] == 6'h00;
  endproperty
  a_det_upper_zero: assert property (p_det_upper_zero) else $error("det upper");

  property p_cap_write;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      WR && ADDR == 10'h027 |=> flt_reg == ($past(WDATA) & 8'h3f);
  endproperty
  a_cap_write: assert property (p_cap_write) else $error("filter write");

  property p_flt_hold;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      !(WR && ADDR == 10'h027) |=> $stable(flt_reg);
  endproperty
  a_flt_hold: assert property (p_flt_hold) else $error("filter changed");

  property p_amp_reset;
    @(posedge CLK_SYS) $rose(RESET_N) |-> FLT_OUT.filter_amp_on && FLT_OUT.filter_bias_on;
  endproperty
  a_amp_reset: assert property (p_amp_reset) else $error("amp reset");

  property p_band_read;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      RD && ADDR == 10'h028 |=> RDATA == {3'h0, $past(band_sync)};
  endproperty
  a_band_read: assert property (p_band_read) else $error("band read");

  property p_scr_write;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      WR && ADDR == 10'h0fe ##1 RD && ADDR == 10'h0fe |=> RDATA == $past(WDATA, 2);
  endproperty
  a_scr_write: assert property (p_scr_write) else $error("scratch");

  sequence s_no_update;
    !update [*2];
  endsequence
  property p_buffered;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      s_no_update |=> $stable(DET_OUT) && $stable(FLT_OUT);
  endproperty
  a_buffered: assert property (p_buffered) else $error("buffer leak");

  property p_update_apply;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      update |=> DET_OUT == $past(det_reg[1:0]);
  endproperty
  a_update_apply: assert property (p_update_apply) else $error("update");

  property p_update_flt;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      update |=> FLT_OUT == $past(flt_reg[5:0]);
  endproperty
  a_update_flt: assert property (p_update_flt) else $error("filter update");

  property p_comp_write;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      WR && ADDR == `PLC_OFF_DET |=> det_reg[0] == $past(WDATA[0]);
  endproperty
  a_comp_write: assert property (p_comp_write) else $error("comparator enable write");

  property p_flt_reset_val;
    @(posedge CLK_SYS) $rose(RESET_N) |-> flt_reg == `PLC_RST_FLT;
  endproperty
  a_flt_reset_val: assert property (p_flt_reset_val) else $error("filter reset");

  property p_det_out_reset;
    @(posedge CLK_SYS) $rose(RESET_N) |-> DET_OUT == rst_det_val[1:0];
  endproperty
  a_det_out_reset: assert property (p_det_out_reset) else $error("detector out reset");

  ////////////////////////////////////////////////////////////////////////
  // Scratch bytes are live and touch nothing else
  property p_scr_c_write;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      WR && ADDR == `PLC_OFF_SCR_C |=> scr_c_reg == $past(WDATA);
  endproperty
  a_scr_c_write: assert property (p_scr_c_write) else $error("scratch c");

  property p_scr_reset;
    @(posedge CLK_SYS) $rose(RESET_N) |->
      scr_b_reg == `PLC_RST_SCR && scr_c_reg == `PLC_RST_SCR;
  endproperty
  a_scr_reset: assert property (p_scr_reset) else $error("scratch reset");

  sequence s_scr_write;
    WR && (ADDR == `PLC_OFF_SCR_B || ADDR == `PLC_OFF_SCR_C);
  endsequence
  property p_scr_isolated;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      s_scr_write |=> $stable(det_reg) && $stable(flt_reg)
        && $stable(DET_OUT) && $stable(FLT_OUT);
  endproperty
  a_scr_isolated: assert property (p_scr_isolated) else $error("scratch side effect");

  ////////////////////////////////////////////////////////////////////////
  // Band register has no write path
  sequence s_band_write;
    WR && ADDR == `PLC_OFF_BAND;
  endsequence
  property p_band_ignore;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      s_band_write |=> $stable(det_reg) && $stable(flt_reg) && $stable(scr_b_reg)
        && $stable(scr_c_reg);
  endproperty
  a_band_ignore: assert property (p_band_ignore) else $error("band write");

  property p_rdata_idle;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      !RD |=> RDATA == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data idle");
endmodule

// ===== sim/tb.sv
`timescale 1ns/1ps
`include "plc_defs.svh"
module tb;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [9:0] addr = 10'h000;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic rd_d = 1'b0;
  logic [4:0] cal_band = 5'h00;
  logic [7:0] rdata;
  plc_pkg::plc_det_t det_out;
  plc_pkg::plc_flt_t flt_out;
  logic [7:0] exp_q[$];
  logic [7:0] d, f, b;
  logic [7:0] pd = `PLC_RST_DET;
  logic [7:0] pf = `PLC_RST_FLT;
  int num_errors = 0;
  int checks_done = 0;
  always #50 clk_sys = ~clk_sys;
  plc_regs dut (.CLK_SYS(clk_sys), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr_s), .RD(rd_s), .CAL_BAND(cal_band), .RDATA(rdata), .DET_OUT(det_out),
    .FLT_OUT(flt_out));
  task automatic check(input logic [7:0] seen, input logic [7:0] expv);
    checks_done++;
    if (seen !== expv) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask
  // One bus cycle; a read notes its expected data
  task automatic bus(input logic w, input logic r, input logic [9:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    wr_s <= w;
    rd_s <= r;
    addr <= a;
    wdata <= v;
    if (r) exp_q.push_back(v);
  endtask
  // Reset values on the outputs and on read-back; band reads back the live cal_band
  task automatic read_defaults;
    check({6'h00, det_out}, `PLC_RST_DET);
    check({2'h0, flt_out}, `PLC_RST_FLT);
    bus(0, 1, `PLC_OFF_DET, `PLC_RST_DET);
    bus(0, 1, `PLC_OFF_FLT, `PLC_RST_FLT);
    bus(0, 1, `PLC_OFF_SCR_B, `PLC_RST_SCR);
    bus(0, 1, `PLC_OFF_SCR_C, `PLC_RST_SCR);
    bus(0, 1, `PLC_OFF_BAND, {3'h0, cal_band});
    bus(0, 0, 10'h000, 8'h00);
  endtask
  task automatic tally_and_finish;
    $display("Errors %0d, checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) rd_d <= rd_s;
  always @(negedge clk_sys) begin
    if (rd_d) check(rdata, exp_q.pop_front());
  end
  initial begin
    #3000000;
    num_errors++;
    tally_and_finish;
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(64773));
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    read_defaults();
    bus(1, 0, 10'h155, 8'ha5);
    bus(0, 1, 10'h155, 8'h00);
    bus(1, 0, `PLC_OFF_SCR_B, 8'h5a);
    bus(0, 1, `PLC_OFF_SCR_B, 8'h5a);
    bus(0, 0, 10'h000, 8'h00);
    repeat (8) begin
      d = 8'($urandom) & `PLC_DET_MASK;
      f = 8'($urandom) & `PLC_FLT_MASK;
      b = 8'($urandom);
      @(posedge clk_sys);
      cal_band <= b[4:0];
      bus(1, 0, `PLC_OFF_DET, d);
      bus(1, 0, `PLC_OFF_FLT, f);
      bus(1, 0, `PLC_OFF_BAND, ~b);
      bus(1, 0, `PLC_OFF_SCR_B, b);
      bus(1, 0, `PLC_OFF_SCR_C, ~b);
      bus(0, 1, `PLC_OFF_DET, d & `PLC_DET_MASK);
      bus(0, 1, `PLC_OFF_FLT, f & `PLC_FLT_MASK);
      bus(0, 1, `PLC_OFF_BAND, {3'h0, b[4:0]});
      bus(0, 1, `PLC_OFF_SCR_B, b);
      bus(0, 1, `PLC_OFF_SCR_C, ~b);
      bus(1, 0, `PLC_OFF_UPDATE, 8'hfe);
      bus(0, 0, 10'h000, 8'h00);
      @(posedge clk_sys);
      #1;
      check({6'h00, det_out}, pd);
      check({2'h0, flt_out}, pf);
      bus(1, 0, `PLC_OFF_UPDATE, 8'h01);
      bus(0, 0, 10'h000, 8'h00);
      @(posedge clk_sys);
      #1;
      pd = d & `PLC_DET_MASK;
      pf = f & `PLC_FLT_MASK;
      check({6'h00, det_out}, pd);
      check({2'h0, flt_out}, pf);
    end
    // Reset in mid-run must restore every default
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    read_defaults();
    repeat (3) @(posedge clk_sys);
    tally_and_finish;
  end
endmodule
